// *** verilog/fcl_loader.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// write-side word buffer
module fcl_buf
#(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("buffer depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fcl_buf_st_t;

  fcl_buf_st_t st_ff;
  fcl_buf_st_t nxt_st;
  logic push;
  logic pop;

  // honest flags straight from the count
  assign in_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o = st_ff.mem[st_ff.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // pointer and count update; flush drops everything held
  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data_i;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i)
    begin
      nxt_st.wp = '0;
      nxt_st.rp = '0;
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
endmodule // fcl_buf

////////////////////////////////////////////////////////////////////////////
// reset-time configuration, offset loading and endian steering
module fcl_loader
#(
  parameter int OFS_W = fcl_pkg::OFS_W_DEF,
  parameter int BUF_DEPTH = fcl_pkg::BUF_DEPTH_DEF
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // reset and configuration pins
  input wire fcl_pkg::fcl_pins_t cfg_pins_i,
  // wide port write side
  input wire logic wide_wr_valid_i,
  input wire logic [fcl_pkg::WIDE_W-1:0] wide_port_data_i,
  output logic wide_port_full_n_o,
  // narrow transmit port
  input wire logic tx_rd_i,
  output logic [fcl_pkg::HALF_W-1:0] tx_port_data_o,
  output logic tx_port_empty_n_o,
  // narrow receive port
  input wire logic rx_wr_i,
  input wire logic [fcl_pkg::HALF_W-1:0] rx_port_data_i,
  output logic rx_port_full_n_o,
  output logic [fcl_pkg::WIDE_W-1:0] rx_word_o,
  output logic rx_word_valid_o,
  // configuration state
  output fcl_pkg::fcl_ofs_t ofs_o,
  output fcl_pkg::fcl_mode_t mode_o
);
  import fcl_pkg::*;

  localparam int SER_BITS = NUM_OFS * OFS_W;

  if (OFS_W < OFS_W_MIN || OFS_W > OFS_W_MAX)
  begin : g_bad_width
    $error("offset width must be 8, 9 or 10");
  end

  typedef struct packed {
    logic [PIN_N-1:0] sy0;
    logic [PIN_N-1:0] sy1;
    logic [PIN_N-1:0] sy2;
    fcl_pins_t lvl;
    fcl_state_t state;
    fcl_method_t method;
    logic [1:0] wcnt;
    logic [1:0] pcnt;
    logic [5:0] scnt;
    logic [SER_MAX-1:0] sr;
    logic samp_pend;
    fcl_mode_t mode;
    fcl_ofs_t ofs;
    logic wflag;
    logic f2_run;
    logic [1:0] f2cnt;
    logic rxflag;
    logic [WIDE_W-1:0] word;
    logic have;
    logic tx_or;
    logic [HALF_W-1:0] tx_data;
    logic rx_half;
    logic [HALF_W-1:0] rx_first;
    logic [WIDE_W-1:0] rx_word;
    logic rx_valid;
  } fcl_st_t;

  fcl_st_t st_ff;
  fcl_st_t nxt_st;
  logic [PIN_N-1:0] agree;
  fcl_pins_t lvl_nxt;
  logic rise1;
  logic rise2;
  logic par_prog;
  logic wr_acc;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [WIDE_W-1:0] buf_out_data;
  logic buf_flush;
  logic tx_pop;
  logic tx_adv;
  logic [OFS_W_MAX-1:0] preset;

  // a pin change counts once the second and third stages agree
  assign agree = ~(st_ff.sy1 ^ st_ff.sy2);
  assign lvl_nxt = fcl_pins_t'((agree & st_ff.sy2) | (~agree & st_ff.lvl));
  assign rise1 = lvl_nxt.fifo1_master_reset_n
    & ~st_ff.lvl.fifo1_master_reset_n;
  assign rise2 = lvl_nxt.fifo2_master_reset_n
    & ~st_ff.lvl.fifo2_master_reset_n;

  // parallel loading keeps the wide port open while the buffer is bypassed
  assign par_prog = (st_ff.state == ST_PROG) && (st_ff.method == PM_PARALLEL);
  assign wide_port_full_n_o = st_ff.wflag & (par_prog | buf_in_ready);
  assign wr_acc = wide_wr_valid_i & wide_port_full_n_o;
  assign buf_in_valid = wide_wr_valid_i & st_ff.wflag
    & (st_ff.state == ST_RUN);
  assign buf_flush = ~st_ff.lvl.fifo1_master_reset_n
    | ~st_ff.lvl.fifo1_partial_reset_n;

  // preset selection from the two flag-select pins
  assign preset = (st_ff.lvl.flag_select0_serial_data
    && st_ff.lvl.flag_select1_serial_enable_n) ? PRESET_64 :
    st_ff.lvl.flag_select1_serial_enable_n ? PRESET_16 : PRESET_8;

  // transmit advance: fall-through refills an idle output by itself
  assign tx_adv = st_ff.mode.fifo1_first_word_fallthrough
    ? (~st_ff.tx_or | tx_rd_i) : tx_rd_i;

  fcl_buf #(
    .WIDTH(WIDE_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(buf_flush),
    .in_valid_i(buf_in_valid),
    .in_data_i(wide_port_data_i),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_out_valid),
    .out_data_o(buf_out_data),
    .out_ready_i(tx_pop)
  );

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    nxt_st = st_ff;
    tx_pop = 1'b0;
    nxt_st.sy0 = cfg_pins_i;
    nxt_st.sy1 = st_ff.sy0;
    nxt_st.sy2 = st_ff.sy1;
    nxt_st.lvl = lvl_nxt;
    nxt_st.rx_valid = 1'b0;

    // timing mode is taken one clock after the release
    if (st_ff.samp_pend)
    begin
      nxt_st.samp_pend = 1'b0;
      nxt_st.mode.fifo1_first_word_fallthrough =
        ~st_ff.lvl.endian_fallthrough_select;
      nxt_st.mode.fifo2_first_word_fallthrough =
        ~st_ff.lvl.endian_fallthrough_select;
    end

    // fifo1 configuration sequence
    case (st_ff.state)
      ST_RESET:
      begin
        if (rise1)
        begin
          nxt_st.samp_pend = 1'b1;
          nxt_st.mode.big_endian =
            st_ff.lvl.endian_fallthrough_select;
          nxt_st.state = ST_WAIT;
          nxt_st.wcnt = RST_WAIT_LOAD;
          nxt_st.method = PM_NONE;
          if (st_ff.lvl.serial_program_select_n
            && (st_ff.lvl.flag_select0_serial_data
            || st_ff.lvl.flag_select1_serial_enable_n))
          begin
            nxt_st.method = PM_PRESET;
            nxt_st.ofs.fifo1_almost_full_offset = preset;
            nxt_st.ofs.fifo1_almost_empty_offset = preset;
            if (rise2)
            begin
              nxt_st.ofs.fifo2_almost_full_offset = preset;
              nxt_st.ofs.fifo2_almost_empty_offset = preset;
            end
          end
          else if (st_ff.lvl.serial_program_select_n && rise2)
          begin
            nxt_st.method = PM_PARALLEL;
            nxt_st.state = ST_PROG;
            nxt_st.pcnt = PAR_Y1;
          end
          else if (!st_ff.lvl.serial_program_select_n && rise2
            && st_ff.lvl.flag_select1_serial_enable_n
            && !st_ff.lvl.flag_select0_serial_data)
          begin
            nxt_st.method = PM_SERIAL;
            nxt_st.state = ST_PROG;
            nxt_st.scnt = '0;
          end
        end
      end
      ST_WAIT:
      begin
        // a partial reset held low keeps the count at its start
        if (!st_ff.lvl.fifo1_partial_reset_n)
          nxt_st.wcnt = RST_WAIT_LOAD;
        else if (st_ff.wcnt == '0)
          nxt_st.state = ST_RUN;
        else
          nxt_st.wcnt = st_ff.wcnt - 1'b1;
      end
      ST_PROG:
      begin
        if (st_ff.method == PM_PARALLEL)
        begin
          if (wr_acc)
          begin
            // low data bits carry the value, top bit most significant
            case (st_ff.pcnt)
              PAR_Y1: nxt_st.ofs.fifo1_almost_full_offset =
                OFS_W_MAX'(wide_port_data_i[OFS_W-1:0]);
              PAR_X1: nxt_st.ofs.fifo1_almost_empty_offset =
                OFS_W_MAX'(wide_port_data_i[OFS_W-1:0]);
              PAR_Y2: nxt_st.ofs.fifo2_almost_full_offset =
                OFS_W_MAX'(wide_port_data_i[OFS_W-1:0]);
              default: nxt_st.ofs.fifo2_almost_empty_offset =
                OFS_W_MAX'(wide_port_data_i[OFS_W-1:0]);
            endcase
            nxt_st.pcnt = st_ff.pcnt + 1'b1;
            if (st_ff.pcnt == PAR_X2)
              nxt_st.state = ST_RUN;
          end
        end
        // serial pins are clocked by clk_i while loading; the agree filter
        // would swallow a data bit that changes on every clock
        else if (!cfg_pins_i.flag_select1_serial_enable_n)
        begin
          // msb first; after the last bit y1 sits on top, x2 at the bottom
          nxt_st.sr = {st_ff.sr[SER_MAX-2:0],
            cfg_pins_i.flag_select0_serial_data};
          nxt_st.scnt = st_ff.scnt + 1'b1;
          if (st_ff.scnt == 6'(SER_BITS - 1))
          begin
            nxt_st.state = ST_RUN;
            nxt_st.ofs = '0;
            nxt_st.ofs.fifo1_almost_full_offset[OFS_W-1:0] =
              nxt_st.sr[4*OFS_W-1 -: OFS_W];
            nxt_st.ofs.fifo1_almost_empty_offset[OFS_W-1:0] =
              nxt_st.sr[3*OFS_W-1 -: OFS_W];
            nxt_st.ofs.fifo2_almost_full_offset[OFS_W-1:0] =
              nxt_st.sr[2*OFS_W-1 -: OFS_W];
            nxt_st.ofs.fifo2_almost_empty_offset[OFS_W-1:0] =
              nxt_st.sr[OFS_W-1:0];
          end
        end
      end
      default:
      begin
        // partial reset clears flags and drops the buffered words; config stays as it is
        if (!st_ff.lvl.fifo1_partial_reset_n)
        begin
          nxt_st.state = ST_WAIT;
          nxt_st.wcnt = RST_WAIT_LOAD;
        end
      end
    endcase
    // filtered next level, so the release cycle is not pulled back
    if (!lvl_nxt.fifo1_master_reset_n)
      nxt_st.state = ST_RESET;

    // wide flag stays low through serial loading, high one edge after
    nxt_st.wflag = ((st_ff.state == ST_RUN) || par_prog)
      && (nxt_st.state != ST_RESET)
      && (nxt_st.state != ST_WAIT);

    // fifo2 write side comes up two clocks after its own release
    if (!st_ff.lvl.fifo2_master_reset_n || !st_ff.lvl.fifo2_partial_reset_n)
    begin
      nxt_st.f2_run = 1'b0;
      nxt_st.f2cnt = F2_WAIT_LOAD;
      nxt_st.rx_half = 1'b0;
    end
    else if (st_ff.f2cnt != '0)
      nxt_st.f2cnt = st_ff.f2cnt - 1'b1;
    else
      nxt_st.f2_run = 1'b1;
    // receive flag waits for offset loading to finish
    nxt_st.rxflag = nxt_st.f2_run && (st_ff.state != ST_PROG)
      && (st_ff.state != ST_RESET);

    // transmit side splits long words into halves in endian order
    if (tx_adv)
    begin
      if (st_ff.have)
      begin
        nxt_st.tx_data = st_ff.mode.big_endian
          ? st_ff.word[HALF_W-1:0] : st_ff.word[WIDE_W-1:HALF_W];
        nxt_st.have = 1'b0;
        nxt_st.tx_or = 1'b1;
      end
      else if (buf_out_valid)
      begin
        tx_pop = 1'b1;
        nxt_st.word = buf_out_data;
        nxt_st.tx_data = st_ff.mode.big_endian
          ? buf_out_data[WIDE_W-1:HALF_W]
          : buf_out_data[HALF_W-1:0];
        nxt_st.have = 1'b1;
        nxt_st.tx_or = 1'b1;
      end
      else
        nxt_st.tx_or = 1'b0;
    end
    if (buf_flush)
    begin
      nxt_st.have = 1'b0;
      nxt_st.tx_or = 1'b0;
    end

    // receive side packs two halves into one long word
    if (rx_wr_i && st_ff.rxflag)
    begin
      if (!st_ff.rx_half)
      begin
        nxt_st.rx_first = rx_port_data_i;
        nxt_st.rx_half = 1'b1;
      end
      else
      begin
        nxt_st.rx_word = st_ff.mode.big_endian
          ? {st_ff.rx_first, rx_port_data_i}
          : {rx_port_data_i, st_ff.rx_first};
        nxt_st.rx_valid = 1'b1;
        nxt_st.rx_half = 1'b0;
      end
    end
  end

  // one register for the whole state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // outputs; standard mode shows the empty flag, fall-through output ready
  assign tx_port_data_o = st_ff.tx_data;
  assign tx_port_empty_n_o = st_ff.mode.fifo1_first_word_fallthrough
    ? st_ff.tx_or : (st_ff.have | buf_out_valid);
  assign rx_port_full_n_o = st_ff.rxflag;
  assign rx_word_o = st_ff.rx_word;
  assign rx_word_valid_o = st_ff.rx_valid;
  assign ofs_o = st_ff.ofs;
  assign mode_o = st_ff.mode;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_endian_latch: assert property (
    rise1 && st_ff.state == ST_RESET |=> mode_o.big_endian ==
      $past(st_ff.lvl.endian_fallthrough_select))
    else $error("endian choice not latched at reset release");

  a_mode_sample: assert property (
    st_ff.samp_pend |=> mode_o.fifo1_first_word_fallthrough ==
      !$past(st_ff.lvl.endian_fallthrough_select))
    else $error("timing mode not sampled after release");

  a_flag_two_clk: assert property (
    st_ff.state == ST_RESET && rise1 && nxt_st.state == ST_WAIT
      ##1 st_ff.lvl.fifo1_master_reset_n [*2]
    |-> !wide_port_full_n_o ##1 st_ff.wflag)
    else $error("full flag not high two clocks after reset");

  a_preset_load: assert property (
    st_ff.state == ST_RESET && rise1 && st_ff.lvl.serial_program_select_n
      && st_ff.lvl.flag_select0_serial_data
      && st_ff.lvl.flag_select1_serial_enable_n
    |=> ofs_o.fifo1_almost_full_offset == PRESET_64
      && ofs_o.fifo1_almost_empty_offset == PRESET_64)
    else $error("preset 64 not loaded");

  a_fifo2_keep: assert property (
    rise2 && !rise1 && st_ff.state != ST_PROG |=>
      $stable(ofs_o.fifo2_almost_full_offset)
      && $stable(ofs_o.fifo2_almost_empty_offset))
    else $error("fifo2 offsets changed without joint release");

  a_par_first: assert property (
    par_prog && wr_acc && st_ff.pcnt == PAR_Y1 |=>
      ofs_o.fifo1_almost_full_offset[OFS_W-1:0] ==
      $past(wide_port_data_i[OFS_W-1:0]))
    else $error("first parallel write did not load y1");

  a_par_done: assert property (
    par_prog && wr_acc && st_ff.pcnt == PAR_X2 && st_ff.f2_run
      ##1 st_ff.lvl.fifo2_master_reset_n
    |=> rx_port_full_n_o)
    else $error("receive flag not raised after parallel load");

  a_ser_shift: assert property (
    st_ff.state == ST_PROG && st_ff.method == PM_SERIAL
      && !cfg_pins_i.flag_select1_serial_enable_n
    |=> st_ff.scnt == $past(st_ff.scnt) + 6'h01)
    else $error("serial bit not counted");

  a_ser_flag: assert property (
    st_ff.state == ST_PROG && st_ff.method == PM_SERIAL
      && !cfg_pins_i.flag_select1_serial_enable_n
      && st_ff.scnt == 6'(SER_BITS - 1)
      ##1 st_ff.lvl.fifo1_master_reset_n
      && st_ff.lvl.fifo1_partial_reset_n
    |-> !wide_port_full_n_o ##1 st_ff.wflag)
    else $error("wide flag not raised after last serial bit");

  a_ser_low: assert property (
    st_ff.state == ST_PROG && st_ff.method == PM_SERIAL
    |-> !rx_port_full_n_o && !wide_port_full_n_o)
    else $error("a full flag high during serial loading");

  a_partial_keep: assert property (
    !st_ff.lvl.fifo1_partial_reset_n && st_ff.lvl.fifo1_master_reset_n
      && st_ff.state != ST_PROG && !st_ff.samp_pend
    |=> $stable(ofs_o) && $stable(mode_o) && !st_ff.wflag)
    else $error("partial reset changed configuration");

  a_tx_order: assert property (
    tx_pop && mode_o.big_endian && !buf_flush |=>
      tx_port_data_o == $past(buf_out_data[WIDE_W-1:HALF_W]))
    else $error("big-endian transmit did not start with upper half");

  a_std_hold: assert property (
    !mode_o.fifo1_first_word_fallthrough && !tx_rd_i |=>
      $stable(tx_port_data_o))
    else $error("standard mode output moved without a read");

  a_first_word_fallthrough_first: assert property (
    mode_o.fifo1_first_word_fallthrough && !st_ff.tx_or && !st_ff.have
      && buf_out_valid && !buf_flush
    |=> tx_port_empty_n_o)
    else $error("first word did not fall through");

  a_rx_pack: assert property (
    rx_wr_i && rx_port_full_n_o && st_ff.rx_half && mode_o.big_endian
      && st_ff.lvl.fifo2_master_reset_n && st_ff.lvl.fifo2_partial_reset_n
    |=> rx_word_valid_o && rx_word_o[WIDE_W-1:HALF_W] ==
      $past(st_ff.rx_first))
    else $error("big-endian receive packing wrong");
endmodule // fcl_loader
`default_nettype wire

// *** verilog/fcl_pkg.sv ***
`default_nettype none
package fcl_pkg;

  // port widths
  localparam int WIDE_W = 36;
  localparam int HALF_W = 18;
  // offset register width, widest depth variant
  localparam int OFS_W_MAX = 10;
  localparam int OFS_W_DEF = 10;
  localparam int OFS_W_MIN = 8;
  // offset registers in a serial or parallel load
  localparam int NUM_OFS = 4;
  localparam int SER_MAX = NUM_OFS * OFS_W_MAX;
  // words in the write-side buffer
  localparam int BUF_DEPTH_DEF = 8;
  // write clock cycles from reset release to full flag high
  localparam int RST_FLAG_CYC = 2;
  localparam logic [1:0] RST_WAIT_LOAD = 2'(RST_FLAG_CYC - 2);
  localparam logic [1:0] F2_WAIT_LOAD = 2'(RST_FLAG_CYC - 1);

  // preset offsets selected by the flag-select pins
  localparam logic [OFS_W_MAX-1:0] PRESET_64 = 10'h040;
  localparam logic [OFS_W_MAX-1:0] PRESET_16 = 10'h010;
  localparam logic [OFS_W_MAX-1:0] PRESET_8 = 10'h008;

  // parallel load order: y1, x1, y2, x2
  localparam logic [1:0] PAR_Y1 = 2'h0;
  localparam logic [1:0] PAR_X1 = 2'h1;
  localparam logic [1:0] PAR_Y2 = 2'h2;
  localparam logic [1:0] PAR_X2 = 2'h3;

  // reset and configuration pins, asynchronous to clk_i except the serial pins while loading
  typedef struct packed {
    logic fifo1_master_reset_n;
    logic fifo2_master_reset_n;
    logic fifo1_partial_reset_n;
    logic fifo2_partial_reset_n;
    logic endian_fallthrough_select;
    logic serial_program_select_n;
    logic flag_select0_serial_data;
    logic flag_select1_serial_enable_n;
  } fcl_pins_t;
  localparam int PIN_N = $bits(fcl_pins_t);

  // the four offset registers
  typedef struct packed {
    logic [OFS_W_MAX-1:0] fifo1_almost_full_offset;
    logic [OFS_W_MAX-1:0] fifo1_almost_empty_offset;
    logic [OFS_W_MAX-1:0] fifo2_almost_full_offset;
    logic [OFS_W_MAX-1:0] fifo2_almost_empty_offset;
  } fcl_ofs_t;

  // latched operating mode
  typedef struct packed {
    logic big_endian;
    logic fifo1_first_word_fallthrough;
    logic fifo2_first_word_fallthrough;
  } fcl_mode_t;

  // offset programming method
  typedef enum logic [1:0] {
    PM_NONE = 2'h0,
    PM_PRESET = 2'h1,
    PM_PARALLEL = 2'h2,
    PM_SERIAL = 2'h3
  } fcl_method_t;

  // fifo1 configuration sequence, gray coded in declaration order
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_WAIT = 3'h1,
    ST_PROG = 3'h3,
    ST_RUN = 3'h2
  } fcl_state_t;

endpackage
`default_nettype wire

// *** sim/fcl_host.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// host model driving the reset and configuration pins
module fcl_host
(
  // clock
  input wire logic clk_i,
  // pins toward the loader
  output var fcl_pkg::fcl_pins_t pins_o
);
  import fcl_pkg::*;

  // both master resets low, partial resets idle
  initial pins_o = 8'h30;

  // master reset with a configuration, fifo2 released late if not joint
  task automatic mreset(input logic be, spm_n, fs0, fs1, joint);
    @(posedge clk_i);
    pins_o.fifo1_master_reset_n <= 1'b0;
    pins_o.fifo2_master_reset_n <= 1'b0;
    pins_o.endian_fallthrough_select <= be;
    pins_o.serial_program_select_n <= spm_n;
    pins_o.flag_select0_serial_data <= fs0;
    pins_o.flag_select1_serial_enable_n <= fs1;
    repeat (6) @(posedge clk_i);
    pins_o.fifo1_master_reset_n <= 1'b1;
    pins_o.fifo2_master_reset_n <= joint;
    repeat (6) @(posedge clk_i);
    pins_o.fifo2_master_reset_n <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  // serial offsets, msb first, enable low only while shifting
  task automatic shift(input logic [39:0] v);
    for (int i = 39; i >= 0; i--)
    begin
      @(posedge clk_i);
      pins_o.flag_select0_serial_data <= v[i];
      pins_o.flag_select1_serial_enable_n <= 1'b0;
    end
    @(posedge clk_i);
    pins_o.flag_select1_serial_enable_n <= 1'b1;
    pins_o.flag_select0_serial_data <= ~v[0];
  endtask

  // partial reset of both fifos, longer than the sync delay
  task automatic partial();
    @(posedge clk_i);
    pins_o.fifo1_partial_reset_n <= 1'b0;
    pins_o.fifo2_partial_reset_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    pins_o.fifo1_partial_reset_n <= 1'b1;
    pins_o.fifo2_partial_reset_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // fcl_host
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// self-checking bench for the configuration loader
module tb_top;
  import fcl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  fcl_pins_t pins;
  logic wr_v = 1'b0, rd = 1'b0, rx_wr = 1'b0, be, rx_v, full_n;
  logic tx_e, rx_f;
  logic [35:0] wr_d = 36'h0, w, rx_w;
  logic [17:0] rx_d = 18'h0, tx_d;
  logic [9:0] v [4];
  logic [39:0] exp_o;
  fcl_ofs_t ofs;
  fcl_mode_t mode;
  int err_count = 0, n_tests = 0, r;

  fcl_host fcl_host_i (.clk_i(clk_i), .pins_o(pins));
  fcl_loader fcl_loader_i (.clk_i(clk_i), .rst_i(rst_i), .cfg_pins_i(pins),
    .wide_wr_valid_i(wr_v), .wide_port_data_i(wr_d),
    .wide_port_full_n_o(full_n), .tx_rd_i(rd), .tx_port_data_o(tx_d),
    .tx_port_empty_n_o(tx_e), .rx_wr_i(rx_wr), .rx_port_data_i(rx_d),
    .rx_port_full_n_o(rx_f), .rx_word_o(rx_w), .rx_word_valid_o(rx_v),
    .ofs_o(ofs), .mode_o(mode));

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [9:0] preset_val(input logic fs1, fs0);
    return fs1 & fs0 ? PRESET_64 : fs1 ? PRESET_16 : PRESET_8;
  endfunction

  // bounded wait on a flag: 0 tx data, 1 rx full_n, 2 wide full_n
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    while (n < 300 && (sel == 0 ? tx_e : sel == 1 ? rx_f : full_n) !== 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(40'(n >= 300), 40'h0);
  endtask

  // valid held until an edge that sees full_n high
  task automatic wr_word(input logic [35:0] d);
    int n;
    @(posedge clk_i);
    wr_v <= 1'b1;
    wr_d <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (full_n !== 1'b1 && n < 300);
    wr_v <= 1'b0;
    chk(40'(full_n !== 1'b1), 40'h0);
  endtask

  task automatic rd_half();
    @(posedge clk_i);
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
  endtask

  task automatic rx_pair(input logic [17:0] a, b);
    @(posedge clk_i);
    rx_wr <= 1'b1;
    rx_d <= a;
    @(posedge clk_i);
    rx_d <= b;
    @(posedge clk_i);
    rx_wr <= 1'b0;
    rx_d <= ~b;
    #1;
    for (int n = 0; n < 4 && rx_v !== 1'b1; n++) @(posedge clk_i) #1;
    chk(40'(rx_v), 40'h1);
    chk(40'(rx_w), 40'(be ? {a, b} : {b, a}));
  endtask

  // hang guard, far beyond the expected run
  initial
  begin
    #(20 * 20000);
    err_count++;
    test_done();
  end

  initial
  begin
    r = $urandom(64030);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // presets, both endians, last one with fifo2 released alone
    for (int i = 0; i < 4; i++)
    begin
      be = ~i[0];
      fcl_host_i.mreset(be, 1'b1, i != 1, i != 2, i != 3);
      exp_o = {4{preset_val(i != 2, i != 1)}};
      if (i == 3) exp_o[19:0] = {2{PRESET_8}};
      wait_hi(1);
      wait_hi(2);
      chk(40'(ofs), exp_o);
      chk(40'(mode), 40'({be, ~be, ~be}));
      w = 36'({$urandom, $urandom});
      wr_word(w);
      wait_hi(0);
      if (be) rd_half(); else #1;
      chk(40'(tx_d), 40'(be ? w[35:18] : w[17:0]));
      rd_half();
      chk(40'(tx_d), 40'(be ? w[17:0] : w[35:18]));
      rx_pair(18'($urandom), 18'($urandom));
      $display("preset test %0d done", i);
    end
    // parallel load through the first four wide writes
    fcl_host_i.mreset(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      v[k] = 10'($urandom_range(1020, 1));
      wr_word({26'($urandom), v[k]});
    end
    wait_hi(1);
    chk(40'(ofs), {v[0], v[1], v[2], v[3]});
    chk(40'(tx_e), 40'h0);
    $display("parallel test done");
    // serial load, then a partial reset that must keep it
    be = 1'($urandom);
    fcl_host_i.mreset(be, 1'b0, 1'b0, 1'b1, 1'b1);
    for (int k = 0; k < 4; k++) v[k] = 10'($urandom_range(1020, 1));
    chk(40'({full_n, rx_f}), 40'h0);
    fcl_host_i.shift({v[0], v[1], v[2], v[3]});
    #1;
    chk(40'({full_n, rx_f}), 40'h0);
    @(posedge clk_i) #1;
    chk(40'({full_n, rx_f}), 40'h3);
    chk(40'(ofs), {v[0], v[1], v[2], v[3]});
    fcl_host_i.partial();
    wait_hi(2);
    chk(40'(ofs), {v[0], v[1], v[2], v[3]});
    chk(40'(mode), 40'({be, ~be, ~be}));
    $display("serial test done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
